// ---- hw/ssc_defines.svh ----
// timing constants and limits for the supply supervisor control block
// assumes a single 50 MHz system clock
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
// =====================================================================
// clock
`define SSC_CLK_HZ 50000000
// =====================================================================
// times in their own units
`define SSC_HOLD_MS 200
`define SSC_WDOG_MS 1600
`define SSC_GRACE_US 15
`define SSC_KICK_NS 50
// internal kick driver pulses high after 7/8 of the period
`define SSC_IDLE_NUM 7
`define SSC_IDLE_DEN 8
// =====================================================================
// derived cycle counts (least times round up)
`define SSC_HOLD_CYC ((`SSC_CLK_HZ / 1000) * `SSC_HOLD_MS)
`define SSC_WDOG_CYC ((`SSC_CLK_HZ / 1000) * `SSC_WDOG_MS)
`define SSC_GRACE_CYC ((`SSC_CLK_HZ / 1000000) * `SSC_GRACE_US)
// 50 ns at 20 ns period -> 3 cycles, rounded up
`define SSC_KICK_CYC ((`SSC_KICK_NS * (`SSC_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ---- hw/ssc_pkg.sv ----
// types shared by the supply supervisor control block
// assumes nothing beyond the defines header
package ssc_pkg;
	// =================================================================
	// synchronised analog comparison flags
	typedef struct packed {
		logic above_reset;   // supply above reset_threshold_level
		logic above_battery; // supply above backup_cell_input
		logic fail_low;      // fail_compare_in below fail_threshold_level
	} ssc_analog_s;
	// =================================================================
	// reset sequencer states
	typedef enum logic [1:0] {
		SSC_ST_ASSERT = 2'b00, // cause still present
		SSC_ST_HOLD = 2'b01,   // timing the hold period
		SSC_ST_RUN = 2'b10     // reset released
	} ssc_state_e;
	// ram rail source
	typedef enum logic [1:0] {
		SSC_RAIL_MAIN = 2'b00,
		SSC_RAIL_BACKUP_CELL_INPUT = 2'b01,
		SSC_RAIL_OFF = 2'b10
	} ssc_rail_e;
endpackage

// ---- hw/ssc_sync.sv ----
// two-flop synchroniser for a bundle of asynchronous levels
// assumes inputs come from pins or analog comparators
`timescale 1ns/1ns
`default_nettype none
module ssc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// =================================================================
	// stages
	logic [WIDTH-1:0] meta_r; // first stage, read only by sync_out
	// first flop alone faces metastability
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_r <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
	initial begin
		if (WIDTH < 1) $error("ssc_sync width must be positive");
	end
endmodule
`default_nettype wire

// ---- hw/ssc_timer.sv ----
// up counter with clear and terminal flag
// assumes same clock as its user
`timescale 1ns/1ns
`default_nettype none
module ssc_timer #(
	parameter int LIMIT = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// control
	input wire logic clear, // restart from zero
	input wire logic run,   // count enable
	// status
	output logic done       // count reached LIMIT
);
	// =================================================================
	localparam int W = $clog2(LIMIT + 1);
	logic [W-1:0] count_r; // elapsed cycles
	// counter saturates so done stays high until cleared
	always_ff @(posedge sys_clk) begin
		if (reset || clear) begin
			count_r <= '0;
		end else if (run && !done) begin
			count_r <= count_r + W'(1);
		end
	end
	assign done = (count_r == W'(LIMIT));
	initial begin
		if (LIMIT < 1) $error("ssc_timer limit must be at least one");
	end
endmodule
`default_nettype wire

// ---- hw/ssc_supervisor.sv ----
// supply supervisor control: reset sequencing, watchdog, ram gating
// assumes comparator flags and pins are asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defines.svh"
module ssc_supervisor #(
	parameter int HOLD_CYC = `SSC_HOLD_CYC,
	parameter int WDOG_CYC = `SSC_WDOG_CYC,
	parameter int GRACE_CYC = `SSC_GRACE_CYC,
	parameter int KICK_CYC = `SSC_KICK_CYC
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic reset,
	// analog comparison flags, asynchronous
	input wire ssc_pkg::ssc_analog_s analog_in,
	// processor side
	input wire logic manual_reset_n,
	input wire logic watchdog_kick,
	input wire logic watchdog_kick_driven, // external driver active
	output logic reset_n,
	// power-fail flag pin, always driven, also sensed for the arming strap
	input wire logic power_fail_flag_in,
	output logic power_fail_flag_n,
	output logic power_fail_flag_oe,
	// chip-select gate
	input wire logic chip_select_in_n,
	input wire logic chip_select_out_in, // sensed level for strap
	output logic chip_select_out_n,
	output logic chip_select_out_oe, // transmission gate enabled
	output logic chip_select_pullup, // active pull-up to ram rail
	output logic chip_select_in_hiz,
	// supply switching
	output ssc_pkg::ssc_rail_e ram_rail_sel,
	output logic battery_backup,
	output logic seal_armed,
	// internal kick driver level
	output logic kick_drive_level
);
	// =================================================================
	// elaboration checks
	initial begin
		if (HOLD_CYC < 1 || WDOG_CYC < 8 || GRACE_CYC < 1 || KICK_CYC < 1)
			$error("ssc_supervisor counts too small");
	end
	// =================================================================
	// synchronisers
	ssc_pkg::ssc_analog_s ana; // synchronised flags
	logic [6:0] pin_s; // synchronised pins
	// supply starts low so reset is asserted from power-on
	ssc_sync #(.WIDTH(3), .INIT(3'b000)) u_sync_ana (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in(analog_in),
		.sync_out(ana)
	);
	// kick starts low to match its edge detector, so no false edge
	ssc_sync #(.WIDTH(7), .INIT(7'h5f)) u_sync_pin (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in({manual_reset_n, watchdog_kick, watchdog_kick_driven,
			power_fail_flag_in, chip_select_in_n, chip_select_out_in,
			1'b1}),
		.sync_out(pin_s)
	);
	logic mr_n, kick, kick_drv, pfo_pin, csi_n, cso_pin;
	assign mr_n = pin_s[6];
	assign kick = pin_s[5];
	assign kick_drv = pin_s[4];
	assign pfo_pin = pin_s[3];
	assign csi_n = pin_s[2];
	assign cso_pin = pin_s[1];
	// =================================================================
	// reset sequencer
	ssc_pkg::ssc_state_e state_r;
	logic hold_done, wdog_done, grace_done, idle_done;
	logic seal_r; // seal armed
	logic strap_r; // strap seen low through a whole hold period
	logic seal_pending_r; // seal seen with supply still up
	logic mr_eff; // manual reset as the sequencer sees it
	logic cause; // any level cause holding reset
	logic in_hold, in_reset, backup;
	assign backup = !ana.above_reset && !ana.above_battery;
	assign in_hold = (state_r == ssc_pkg::SSC_ST_HOLD);
	assign in_reset = (state_r != ssc_pkg::SSC_ST_RUN);
	// strap level blinds the manual input during the hold period
	assign mr_eff = (in_hold && strap_r) ? 1'b1 : mr_n;
	assign cause = !ana.above_reset || !mr_eff || backup;
	// cause restarts the hold; watchdog expiry begins a new hold
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ssc_pkg::SSC_ST_ASSERT;
		end else if (cause) begin
			state_r <= ssc_pkg::SSC_ST_ASSERT;
		end else begin
			case (state_r)
				ssc_pkg::SSC_ST_ASSERT:
					state_r <= ssc_pkg::SSC_ST_HOLD;
				ssc_pkg::SSC_ST_HOLD:
					if (hold_done) state_r <= ssc_pkg::SSC_ST_RUN;
				ssc_pkg::SSC_ST_RUN:
					if (wdog_done) state_r <= ssc_pkg::SSC_ST_HOLD;
				default:
					state_r <= ssc_pkg::SSC_ST_ASSERT;
			endcase
		end
	end
	// hold timer runs only in hold, cleared otherwise
	ssc_timer #(.LIMIT(HOLD_CYC)) u_hold (
		.sys_clk(sys_clk),
		.reset(reset),
		.clear(!in_hold),
		.run(1'b1),
		.done(hold_done)
	);
	// reset output is a flop so it never glitches
	always_ff @(posedge sys_clk) begin
		if (reset) reset_n <= 1'b0;
		else reset_n <= !in_reset && !cause;
	end
	// =================================================================
	// freshness seal
	// strap is sampled during the hold; manual reset must stay high
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			strap_r <= 1'b0;
		end else if (state_r == ssc_pkg::SSC_ST_ASSERT) begin
			strap_r <= 1'b1;
		end else if (in_hold && ((pfo_pin && cso_pin) || !mr_n)) begin
			strap_r <= 1'b0;
		end
	end
	// armed when reset releases with strap held; cleared on next rise
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			seal_r <= 1'b0;
		end else if (in_hold && hold_done && strap_r) begin
			seal_r <= 1'b1;
		end else if (state_r == ssc_pkg::SSC_ST_ASSERT && ana.above_reset &&
			!seal_pending_r) begin
			seal_r <= 1'b0;
		end
	end
	// seal stays until supply has first fallen and then risen again
	always_ff @(posedge sys_clk) begin
		if (reset) seal_pending_r <= 1'b0;
		else if (seal_r && ana.above_reset) seal_pending_r <= 1'b1;
		else if (!ana.above_reset) seal_pending_r <= 1'b0;
	end
	assign seal_armed = seal_r;
	// =================================================================
	// watchdog
	logic kick_d_r; // previous kick level for edge detect
	logic kick_edge, wdog_clear;
	logic kick_src;
	// floating input follows the internal driver
	assign kick_src = kick_drv ? kick : kick_drive_level;
	always_ff @(posedge sys_clk) begin
		if (reset) kick_d_r <= 1'b0;
		else kick_d_r <= kick_src;
	end
	// 50 ns pulse spans 3 cycles, so the sampled edge is never missed
	assign kick_edge = kick_src ^ kick_d_r;
	assign wdog_clear = in_reset || cause || kick_edge;
	ssc_timer #(.LIMIT(WDOG_CYC)) u_wdog (
		.sys_clk(sys_clk),
		.reset(reset),
		.clear(wdog_clear),
		.run(1'b1),
		.done(wdog_done)
	);
	// internal driver: low for 7/8 of the period then a short high
	localparam int IDLE_CYC = WDOG_CYC * `SSC_IDLE_NUM / `SSC_IDLE_DEN;
	ssc_timer #(.LIMIT(IDLE_CYC)) u_idle (
		.sys_clk(sys_clk),
		.reset(reset),
		.clear(kick_drive_level || in_reset),
		.run(1'b1),
		.done(idle_done)
	);
	logic [$clog2(KICK_CYC+1)-1:0] pulse_r; // high pulse length
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			kick_drive_level <= 1'b0;
			pulse_r <= '0;
		end else if (idle_done && !kick_drive_level) begin
			kick_drive_level <= 1'b1;
			pulse_r <= '0;
		end else if (kick_drive_level) begin
			pulse_r <= pulse_r + 1'b1;
			if (pulse_r == ($clog2(KICK_CYC+1))'(KICK_CYC - 1))
				kick_drive_level <= 1'b0;
		end
	end
	// =================================================================
	// chip-select gate
	logic gate_r; // transmission gate enabled
	logic grace_r; // grace window active
	logic gate_q_r; // gate as seen by the registered output
	ssc_timer #(.LIMIT(GRACE_CYC)) u_grace (
		.sys_clk(sys_clk),
		.reset(reset),
		.clear(!grace_r),
		.run(1'b1),
		.done(grace_done)
	);
	// gate follows reset; an active cycle keeps it for the grace time
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			gate_r <= 1'b0;
			grace_r <= 1'b0;
		end else if (!in_reset && !cause && !backup) begin
			gate_r <= 1'b1;
			grace_r <= 1'b0;
		end else if (gate_r && !grace_r && !csi_n && !backup) begin
			grace_r <= 1'b1;
		end else if (grace_r && !grace_done && !csi_n && !backup) begin
			gate_r <= 1'b1;
		end else begin
			gate_r <= 1'b0;
			grace_r <= 1'b0;
		end
	end
	// data output from a flop, pulled high while disabled
	always_ff @(posedge sys_clk) begin
		if (reset) chip_select_out_n <= 1'b1;
		else chip_select_out_n <= gate_r ? csi_n : 1'b1;
	end
	// gate pins lag gate_r one cycle to line up with the output flop
	always_ff @(posedge sys_clk) begin
		if (reset) gate_q_r <= 1'b0;
		else gate_q_r <= gate_r;
	end
	assign chip_select_out_oe = gate_q_r;
	assign chip_select_pullup = !gate_q_r;
	assign chip_select_in_hiz = !gate_q_r;
	// =================================================================
	// power-fail flag
	always_ff @(posedge sys_clk) begin
		if (reset) power_fail_flag_n <= 1'b1;
		else if (in_hold) power_fail_flag_n <= 1'b1;
		else if (!ana.above_battery) power_fail_flag_n <= 1'b0;
		else power_fail_flag_n <= !ana.fail_low;
	end
	assign power_fail_flag_oe = 1'b1;
	// =================================================================
	// supply switching
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ram_rail_sel <= ssc_pkg::SSC_RAIL_MAIN;
			battery_backup <= 1'b0;
		end else begin
			battery_backup <= backup && !seal_r;
			if (ana.above_reset || ana.above_battery)
				ram_rail_sel <= ssc_pkg::SSC_RAIL_MAIN;
			else if (seal_r)
				ram_rail_sel <= ssc_pkg::SSC_RAIL_OFF;
			else
				ram_rail_sel <= ssc_pkg::SSC_RAIL_BACKUP_CELL_INPUT;
		end
	end
endmodule
`default_nettype wire

// ---- bench/ssc_supervisor_monitor.sv ----
// checker on the supervisor top ports
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module ssc_supervisor_monitor #(
	parameter int HOLD_CYC = 20,
	parameter int GRACE_CYC = 5
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// watched outputs
	input wire logic reset_n,
	input wire logic power_fail_flag_n,
	input wire logic chip_select_out_n,
	input wire logic chip_select_out_oe,
	input wire logic chip_select_pullup,
	input wire ssc_pkg::ssc_rail_e ram_rail_sel,
	input wire logic battery_backup
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// =========================================================
	// helper counters
	logic [15:0] low_cnt_r; // cycles reset_n has been low
	logic [15:0] grace_cnt_r; // cycles gate open under reset
	// counts stop at the top so a long brownout never wraps
	always_ff @(posedge sys_clk) begin
		if (reset || reset_n)
			low_cnt_r <= 16'h0;
		else if (low_cnt_r != 16'hffff)
			low_cnt_r <= low_cnt_r + 16'h1;
	end
	// only the grace window may leave the gate open in reset
	always_ff @(posedge sys_clk) begin
		if (reset || reset_n || !chip_select_out_oe)
			grace_cnt_r <= 16'h0;
		else if (grace_cnt_r != 16'hffff)
			grace_cnt_r <= grace_cnt_r + 16'h1;
	end
	// =========================================================
	// end of a hold period
	sequence s_release;
		!reset_n ##1 reset_n;
	endsequence
	property p_hold_len;
		s_release |-> $past(low_cnt_r) >= 16'(HOLD_CYC - 2);
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("reset pulse shorter than hold");
	property p_pf_hold;
		s_release |-> $past(power_fail_flag_n);
	endproperty
	a_pf_hold: assert property (p_pf_hold)
		else $error("fail flag low in hold");
	property p_gate_hold;
		s_release |-> $past(!chip_select_out_oe);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gate open in hold");
	property p_pullup;
		chip_select_pullup == !chip_select_out_oe;
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up not opposite gate");
	property p_off_high;
		!chip_select_out_oe |-> chip_select_out_n;
	endproperty
	a_off_high: assert property (p_off_high)
		else $error("closed gate output low");
	property p_grace;
		grace_cnt_r <= 16'(GRACE_CYC + 4);
	endproperty
	a_grace: assert property (p_grace)
		else $error("grace window too long");
	property p_backup;
		battery_backup |-> !reset_n && chip_select_out_n;
	endproperty
	a_backup: assert property (p_backup)
		else $error("backup without reset or cs high");
	property p_rail;
		ram_rail_sel == ssc_pkg::SSC_RAIL_BACKUP_CELL_INPUT |-> !reset_n;
	endproperty
	a_rail: assert property (p_rail)
		else $error("battery rail above threshold");
endmodule
bind ssc_supervisor ssc_supervisor_monitor #(
	.HOLD_CYC(HOLD_CYC),
	.GRACE_CYC(GRACE_CYC)
) ssc_supervisor_monitor_inst (.*);
`default_nettype wire

// ---- bench/ssc_host_model.sv ----
// processor model that services the watchdog
// assumes the bench owns chip select and supply flags
`timescale 1ns/1ns
`default_nettype none
module ssc_host_model #(
	parameter int GAP = 16
) (
	// clock
	input wire logic sys_clk,
	// control from the bench
	input wire logic drive_en,
	input wire logic kick_en,
	// kick pin
	output logic watchdog_kick,
	output logic watchdog_kick_driven
);
	int cnt; // cycles since the last driven toggle
	initial watchdog_kick = 1'b0;
	initial cnt = 0;
	assign watchdog_kick_driven = drive_en;
	// change on the falling edge, away from sampling
	always @(negedge sys_clk) begin
		cnt = cnt + 1;
		// a released line wanders rather than hold its value
		if (!drive_en)
			watchdog_kick = ~watchdog_kick;
		else if (kick_en && cnt >= GAP) begin
			watchdog_kick = ~watchdog_kick;
			cnt = 0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/ssc_supervisor_tb.sv ----
// self-checking bench for the supervisor
// assumes shortened hold, watchdog and grace counts
`timescale 1ns/1ns
`default_nettype none
module ssc_supervisor_tb;
	localparam int H = 20;
	localparam int W = 64;
	localparam int G = 5;
	logic sys_clk = 1'b0, reset = 1'b1;
	ssc_pkg::ssc_analog_s ana = 3'b110; // supply good
	logic mr_n = 1'b1, cs_in_n = 1'b1, pf_in = 1'b1;
	logic drive_en = 1'b1, kick_en = 1'b1;
	logic kick, kick_drv, reset_n, pf_n, cs_out_n, oe, pu, hiz;
	logic backup, seal, kick_lvl;
	ssc_pkg::ssc_rail_e rail;
	int error_cnt = 0, n_compared = 0, tick = 0, n;
	ssc_supervisor #(.HOLD_CYC(H), .WDOG_CYC(W), .GRACE_CYC(G))
	ssc_supervisor_inst (.sys_clk(sys_clk), .reset(reset),
		.analog_in(ana), .manual_reset_n(mr_n),
		.watchdog_kick(kick), .watchdog_kick_driven(kick_drv),
		.reset_n(reset_n), .power_fail_flag_in(pf_in),
		.power_fail_flag_n(pf_n), .power_fail_flag_oe(),
		.chip_select_in_n(cs_in_n), .chip_select_out_in(1'b1),
		.chip_select_out_n(cs_out_n), .chip_select_out_oe(oe),
		.chip_select_pullup(pu), .chip_select_in_hiz(hiz),
		.ram_rail_sel(rail), .battery_backup(backup),
		.seal_armed(seal), .kick_drive_level(kick_lvl));
	ssc_host_model ssc_host_model_inst (.sys_clk(sys_clk),
		.drive_en(drive_en), .kick_en(kick_en),
		.watchdog_kick(kick), .watchdog_kick_driven(kick_drv));
	initial forever #10 sys_clk = ~sys_clk;
	// =========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	// cycles until reset_n shows v, giving up at m
	task automatic wr(input logic v, input int m, output int c);
		c = 0;
		while (reset_n !== v && c < m) begin
			cyc(1);
			c++;
		end
	endtask
	task automatic hold_ok(input string nm);
		wr(1'b1, 500, n);
		chk(nm, 8'(n >= H && n <= H + 8), 8'h1);
	endtask
	// hang guard, ceiling well above the whole sequence
	always @(posedge sys_clk) begin
		tick++;
		if (tick >= 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// =========================================================
	// scenarios
	task automatic t_brownout();
		ana.above_reset = 1'b0;
		cyc(6);
		chk("rst", {7'h0, reset_n}, 8'h0);
		chk("hiz", {7'h0, hiz}, 8'h1);
		ana.above_battery = 1'b0;
		cyc(6);
		chk("pf", {7'h0, pf_n}, 8'h0);
		chk("bk", {7'h0, backup}, 8'h1);
		chk("rail", {6'h0, rail}, 8'h1);
		chk("cs", {7'h0, cs_out_n}, 8'h1);
		ana = 3'b110;
		cyc(10);
		ana.above_reset = 1'b0; // drop again mid hold
		cyc(5);
		ana.above_reset = 1'b1;
		hold_ok("hold2");
	endtask
	task automatic t_manual();
		mr_n = 1'b0;
		cyc(30);
		chk("mr", {7'h0, reset_n}, 8'h0);
		mr_n = 1'b1;
		hold_ok("mrh");
	endtask
	task automatic t_wdog();
		wr(1'b0, 200, n);
		chk("kicked", 8'(n == 200), 8'h1);
		kick_en = 1'b0;
		wr(1'b0, 500, n);
		chk("wd", 8'(n >= W - 17 && n <= W + 8), 8'h1);
		wr(1'b1, 500, n);
		wr(1'b0, 500, n);
		chk("wd2", 8'(n >= W - 2 && n <= W + 8), 8'h1);
		kick_en = 1'b1;
		hold_ok("wdh");
		drive_en = 1'b0;
		wr(1'b0, 300, n);
		chk("float", 8'(n == 300), 8'h1);
		drive_en = 1'b1;
	endtask
	task automatic t_cs();
		cs_in_n = 1'b0;
		cyc(5);
		chk("pass", {7'h0, cs_out_n}, 8'h0);
		chk("pu", {7'h0, pu}, 8'h0);
		cs_in_n = 1'b1;
		cyc(5);
		chk("pass1", {7'h0, cs_out_n}, 8'h1);
		cs_in_n = 1'b0;
		cyc(5);
		mr_n = 1'b0;
		wr(1'b0, 20, n);
		n = 0;
		while (cs_out_n === 1'b0 && n < 50) begin
			cyc(1);
			n++;
		end
		chk("grace", 8'(n >= G - 2 && n <= G + 2), 8'h1);
		mr_n = 1'b1;
		cyc(8);
		chk("shut", {7'h0, cs_out_n}, 8'h1);
		chk("pu1", {7'h0, pu}, 8'h1);
		cs_in_n = 1'b1;
		wr(1'b1, 500, n);
		chk("csh", 8'(n + 8 >= H && n <= H), 8'h1);
	endtask
	task automatic t_pf();
		ana.fail_low = 1'b1;
		cyc(6);
		chk("pf0", {7'h0, pf_n}, 8'h0);
		mr_n = 1'b0;
		cyc(6);
		mr_n = 1'b1;
		cyc(8);
		chk("pfh", {7'h0, pf_n}, 8'h1);
		wr(1'b1, 500, n);
		chk("pfr", 8'(n + 8 >= H && n <= H), 8'h1);
		cyc(6);
		chk("pf0b", {7'h0, pf_n}, 8'h0);
		ana.fail_low = 1'b0;
		cyc(6);
		chk("pf1", {7'h0, pf_n}, 8'h1);
	endtask
	task automatic t_seal();
		pf_in = 1'b0; // strap held low through power-up
		ana = 3'b000;
		cyc(8);
		ana = 3'b110;
		hold_ok("sh");
		ana = 3'b000;
		cyc(8);
		chk("seal", {7'h0, seal}, 8'h1);
		chk("off", {6'h0, rail}, 8'h2);
		pf_in = 1'b1;
		ana = 3'b110;
		hold_ok("sh2");
		cyc(2);
		chk("open", {7'h0, seal}, 8'h0);
		chk("main", {6'h0, rail}, 8'h0);
	endtask
	// =========================================================
	// main sequence
	initial begin
		cyc(3);
		reset = 1'b0;
		cyc(1);
		chk("por", {7'h0, reset_n}, 8'h0);
		chk("seal0", {7'h0, seal}, 8'h0);
		hold_ok("por");
		t_brownout();
		t_manual();
		t_wdog();
		t_cs();
		t_pf();
		t_seal();
		stop_test();
	end
endmodule
`default_nettype wire
